// File: hw/fep_coding.sv
// 100 Mb/s coding datapath: nibble encode/scramble/serialize/MLT-3 on
// transmit, and the reverse on receive, down to MAC nibbles.
// Assumes the MAC side is on i_clk_sys; the line inputs are asynchronous.
`timescale 1ns/1ps
module fep_coding #(
  parameter int BIT_DIV   = 1,
  parameter int LOCK_BITS = 30
) (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_sys_rst,
  input  wire logic                   i_bypass,
  input  wire fep_pkg::fep_tx_in_type i_tx,
  output logic                        o_tx_take,
  output fep_pkg::fep_mlt_type        o_tx_mlt,
  input  wire logic                   i_sig_det,
  input  wire fep_pkg::fep_mlt_type   i_rx_mlt,
  output fep_pkg::fep_rx_out_type     o_rx,
  output logic                        o_rx_lock
);
  import fep_pkg::*;

  // ---------------------------------------------------------------
  // Functions
  // ---------------------------------------------------------------
  function automatic logic [4:0] enc4(input logic [3:0] n);
    logic [4:0] c;
    c = FEP_CG_IDLE;
    case (n)
      4'h0: c = 5'h1e;
      4'h1: c = 5'h09;
      4'h2: c = 5'h14;
      4'h3: c = 5'h15;
      4'h4: c = 5'h0a;
      4'h5: c = 5'h0b;
      4'h6: c = 5'h0e;
      4'h7: c = 5'h0f;
      4'h8: c = 5'h12;
      4'h9: c = 5'h13;
      4'ha: c = 5'h16;
      4'hb: c = 5'h17;
      4'hc: c = 5'h1a;
      4'hd: c = 5'h1b;
      4'he: c = 5'h1c;
      default: c = 5'h1d;
    endcase
    return c;
  endfunction : enc4

  // Returns {valid, nibble}; inverse of enc4
  function automatic logic [4:0] dec5(input logic [4:0] c);
    logic [4:0] r;
    r = 5'h00;
    for (int i = 0; i < 16; i++) begin
      if (enc4(4'(i)) == c) begin
        r = {1'b1, 4'(i)};
      end
    end
    return r;
  endfunction : dec5

  function automatic logic [10:0] lfsr_step(input logic [10:0] s);
    return {s[FEP_TAP_HI-1:0], s[FEP_TAP_HI] ^ s[FEP_TAP_LO]};
  endfunction : lfsr_step

  // Returns {key5, next state}; first key bit lands in bit 4
  function automatic logic [15:0] lfsr_group(input logic [10:0] s);
    logic [10:0] t;
    logic [4:0]  k;
    t = s;
    k = 5'h00;
    for (int i = FEP_GROUP_BITS - 1; i >= 0; i--) begin
      t    = lfsr_step(t);
      k[i] = t[0];
    end
    return {k, t};
  endfunction : lfsr_group

  // ---------------------------------------------------------------
  // Bit enable divider
  // ---------------------------------------------------------------
  logic [7:0] div_reg;
  wire        bit_en = (div_reg == 8'(BIT_DIV - 1));

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst || bit_en) begin
      div_reg <= 8'h00;
    end else begin
      div_reg <= div_reg + 8'h01;
    end
  end

  // ---------------------------------------------------------------
  // Transmit: encoder and scrambler
  // ---------------------------------------------------------------
  fep_tx_state_type tx_state_reg, tx_state_next;
  logic [2:0]       tx_cnt_reg;
  logic [10:0]      tx_lfsr_reg;
  logic [4:0]       tx_sh_reg;
  logic             nrzi_reg;
  logic [1:0]       mlt_ph_reg;
  logic [4:0]       tx_group;

  wire        tx_load = bit_en && (tx_cnt_reg == FEP_GROUP_LAST);
  wire [15:0] tx_scr  = lfsr_group(tx_lfsr_reg);
  wire [4:0]  tx_wire = tx_group ^ tx_scr[15:11];

  always_comb begin
    tx_state_next = tx_state_reg;
    tx_group      = FEP_CG_IDLE;
    if (i_bypass) begin
      tx_group      = i_tx.sym;
      tx_state_next = FEP_TX_IDLE;
    end else begin
      case (tx_state_reg)
        FEP_TX_IDLE: begin
          if (i_tx.en) begin
            tx_group      = FEP_CG_J;
            tx_state_next = FEP_TX_K;
          end
        end
        FEP_TX_K: begin
          tx_group      = FEP_CG_K;
          tx_state_next = FEP_TX_DATA;
        end
        FEP_TX_DATA: begin
          if (i_tx.en) begin
            tx_group = enc4(i_tx.nib);
          end else begin
            tx_group      = FEP_CG_T;
            tx_state_next = FEP_TX_R;
          end
        end
        FEP_TX_R: begin
          tx_group      = FEP_CG_R;
          tx_state_next = FEP_TX_IDLE;
        end
        default: tx_state_next = FEP_TX_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Transmit: serializer, NRZI and MLT-3 split
  // ---------------------------------------------------------------
  wire tx_bit    = tx_sh_reg[FEP_GROUP_BITS-1];
  wire nrzi_next = nrzi_reg ^ tx_bit;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      tx_state_reg <= FEP_TX_IDLE;
      tx_cnt_reg   <= 3'h0;
      tx_lfsr_reg  <= FEP_LFSR_SEED;
      tx_sh_reg    <= FEP_CG_IDLE;
      o_tx_take    <= 1'b0;
    end else begin
      o_tx_take <= tx_load;
      if (bit_en) begin
        tx_cnt_reg <= tx_load ? 3'h0 : tx_cnt_reg + 3'h1;
      end
      if (tx_load) begin
        tx_state_reg <= tx_state_next;
        tx_lfsr_reg  <= tx_scr[10:0];
        tx_sh_reg    <= tx_wire;
      end else if (bit_en) begin
        tx_sh_reg <= {tx_sh_reg[3:0], 1'b0};
      end
    end
  end

  // MLT-3 phase walks 0,+,0,- on each NRZI transition
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      nrzi_reg   <= 1'b0;
      mlt_ph_reg <= 2'h0;
      o_tx_mlt   <= '0;
    end else if (bit_en) begin
      nrzi_reg <= nrzi_next;
      if (nrzi_next != nrzi_reg) begin
        mlt_ph_reg   <= mlt_ph_reg + 2'h1;
        o_tx_mlt.pos <= (mlt_ph_reg == 2'h0);
        o_tx_mlt.neg <= (mlt_ph_reg == 2'h2);
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive: input sync, MLT-3 decode, bit timing
  // ---------------------------------------------------------------
  logic [2:0] rx_s1_reg, rx_s2_reg;
  logic [1:0] rx_lvl_reg;
  logic       rx_nrzi_reg, rx_nrzi_d_reg;
  logic [7:0] rx_ph_reg;

  wire rx_lvl_chg = ({rx_s2_reg[1], rx_s2_reg[0]} != rx_lvl_reg);
  wire rx_sig     = rx_s2_reg[2];
  wire rx_stb     = (rx_ph_reg == 8'(BIT_DIV / 2));
  wire rx_nrz     = rx_nrzi_reg ^ rx_nrzi_d_reg;

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_s1_reg     <= 3'h0;
      rx_s2_reg     <= 3'h0;
      rx_lvl_reg    <= 2'h0;
      rx_nrzi_reg   <= 1'b0;
      rx_nrzi_d_reg <= 1'b0;
      rx_ph_reg     <= 8'h00;
    end else begin
      rx_s1_reg  <= {i_sig_det, i_rx_mlt.pos, i_rx_mlt.neg};
      rx_s2_reg  <= rx_s1_reg;
      rx_lvl_reg <= rx_s2_reg[1:0];
      if (rx_lvl_chg) begin
        rx_nrzi_reg <= ~rx_nrzi_reg;
      end
      // Phase resets on every line transition; sample mid bit
      if (rx_lvl_chg || rx_ph_reg == 8'(BIT_DIV - 1)) begin
        rx_ph_reg <= 8'h00;
      end else begin
        rx_ph_reg <= rx_ph_reg + 8'h01;
      end
      if (rx_stb) begin
        rx_nrzi_d_reg <= rx_nrzi_reg;
      end
    end
  end

  // ---------------------------------------------------------------
  // Receive: parallel word, descrambler, alignment, decoder
  // ---------------------------------------------------------------
  logic [9:0]  rx_raw_reg, rx_key_reg;
  logic [10:0] rx_lfsr_reg;
  logic [7:0]  lock_cnt_reg;
  logic        in_frame_reg;
  logic [2:0]  rx_cnt_reg;

  wire [10:0] rx_lfsr_nx = lfsr_step(rx_lfsr_reg);
  wire        rx_key_bit = o_rx_lock ? rx_lfsr_nx[0] : ~rx_nrz;
  wire        key_match  = (rx_lfsr_nx[0] == ~rx_nrz);
  wire [9:0]  rx_des     = rx_raw_reg ^ rx_key_reg;
  wire        grp_end    = in_frame_reg && (rx_cnt_reg == FEP_GROUP_LAST);
  wire [4:0]  dec_prev   = dec5(rx_des[9:5]);

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      rx_raw_reg   <= 10'h000;
      rx_key_reg   <= 10'h000;
      rx_lfsr_reg  <= FEP_LFSR_SEED;
      lock_cnt_reg <= 8'h00;
      o_rx_lock    <= 1'b0;
    end else if (!rx_sig) begin
      lock_cnt_reg <= 8'h00;
      o_rx_lock    <= 1'b0;
    end else if (rx_stb) begin
      rx_raw_reg <= {rx_raw_reg[8:0], rx_nrz};
      rx_key_reg <= {rx_key_reg[8:0], rx_key_bit};
      // Unlocked: idle is all ones, so the key equals the inverted bit
      rx_lfsr_reg <= o_rx_lock ? rx_lfsr_nx
                               : {rx_lfsr_reg[9:0], ~rx_nrz};
      if (!o_rx_lock) begin
        lock_cnt_reg <= key_match ? lock_cnt_reg + 8'h01 : 8'h00;
        o_rx_lock    <= (lock_cnt_reg == 8'(LOCK_BITS));
      end
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      in_frame_reg <= 1'b0;
      rx_cnt_reg   <= 3'h0;
      o_rx         <= '0;
    end else begin
      o_rx.dv <= 1'b0;
      o_rx.er <= 1'b0;
      if (!o_rx_lock) begin
        in_frame_reg <= 1'b0;
      end else if (rx_stb) begin
        rx_cnt_reg <= grp_end ? 3'h0 : rx_cnt_reg + 3'h1;
        if (!in_frame_reg && rx_des == FEP_PAIR_JK) begin
          in_frame_reg <= 1'b1;
          rx_cnt_reg   <= 3'h0;
          o_rx.dv      <= 1'b1;
          o_rx.nib     <= FEP_PREAMBLE_NIB;
        end else if (grp_end) begin
          if (rx_des == FEP_PAIR_TR || rx_des == FEP_PAIR_IDLE) begin
            in_frame_reg <= 1'b0;
          end else if (rx_des[9:5] == FEP_CG_K) begin
            o_rx.dv  <= 1'b1;
            o_rx.nib <= FEP_PREAMBLE_NIB;
          end else begin
            o_rx.dv  <= 1'b1;
            o_rx.er  <= ~dec_prev[4];
            o_rx.nib <= dec_prev[3:0];
          end
        end
      end
    end
  end

endmodule : fep_coding

// File: hw/fep_pkg.sv
// Shared types and constants for the 100 Mb/s coding datapath.
// Assumes one system clock; line bit timing comes from an enable divider.
package fep_pkg;

  // ---------------------------------------------------------------
  // Code groups
  // ---------------------------------------------------------------
  localparam logic [4:0] FEP_CG_IDLE = 5'h1f;
  localparam logic [4:0] FEP_CG_J    = 5'h18;
  localparam logic [4:0] FEP_CG_K    = 5'h11;
  localparam logic [4:0] FEP_CG_T    = 5'h0d;
  localparam logic [4:0] FEP_CG_R    = 5'h07;
  localparam logic [3:0] FEP_PREAMBLE_NIB = 4'h5;
  localparam logic [9:0] FEP_PAIR_JK   = {FEP_CG_J, FEP_CG_K};
  localparam logic [9:0] FEP_PAIR_TR   = {FEP_CG_T, FEP_CG_R};
  localparam logic [9:0] FEP_PAIR_IDLE = {FEP_CG_IDLE, FEP_CG_IDLE};

  // ---------------------------------------------------------------
  // Counts and scrambler taps
  // ---------------------------------------------------------------
  localparam int         FEP_GROUP_BITS = 5;
  localparam logic [2:0] FEP_GROUP_LAST = 3'h4;
  localparam int         FEP_LFSR_LEN   = 11;
  localparam int         FEP_TAP_HI     = 10;
  localparam int         FEP_TAP_LO     = 8;
  localparam logic [10:0] FEP_LFSR_SEED = 11'h7ff;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    FEP_TX_IDLE, FEP_TX_K, FEP_TX_DATA, FEP_TX_R
  } fep_tx_state_type;

  typedef struct packed {
    logic       en;
    logic [3:0] nib;
    logic [4:0] sym;
  } fep_tx_in_type;

  typedef struct packed {
    logic       dv;
    logic       er;
    logic [3:0] nib;
  } fep_rx_out_type;

  typedef struct packed {
    logic pos;
    logic neg;
  } fep_mlt_type;

endpackage : fep_pkg

// File: verif/fep_coding_props.sv
// Port checker for the coding datapath: line shape, strobes, lock.
// Assumes it is bound into fep_coding and shares its parameters.
`timescale 1ns/1ps
module fep_coding_props #(
  parameter int BIT_DIV   = 1,
  parameter int LOCK_BITS = 30
) (
  input wire logic                    i_clk_sys,
  input wire logic                    i_sys_rst,
  input wire logic                    i_bypass,
  input wire fep_pkg::fep_tx_in_type  i_tx,
  input wire logic                    o_tx_take,
  input wire fep_pkg::fep_mlt_type    o_tx_mlt,
  input wire logic                    i_sig_det,
  input wire fep_pkg::fep_mlt_type    i_rx_mlt,
  input wire fep_pkg::fep_rx_out_type o_rx,
  input wire logic                    o_rx_lock
);
  import fep_pkg::*;
  logic [15:0] gap_reg;
  logic        seen_reg;
  logic        plus_last_reg;
  // Remembers whether the last line excursion was plus
  always_ff @(posedge i_clk_sys) begin
    if (i_sys_rst) begin
      plus_last_reg <= 1'b0;
    end else if (o_tx_mlt.pos || o_tx_mlt.neg) begin
      plus_last_reg <= o_tx_mlt.pos;
    end
  end
  // Cycles since the last group load strobe
  always_ff @(posedge i_clk_sys) begin
    gap_reg <= (i_sys_rst || o_tx_take) ? 16'h0 : gap_reg + 16'h1;
  end
  always_ff @(posedge i_clk_sys) begin
    seen_reg <= i_sys_rst ? 1'b0 : (seen_reg | o_tx_take);
  end
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  sequence s_take;
    seen_reg && o_tx_take;
  endsequence
  sequence s_sig_gone;
    !i_sig_det [*4];
  endsequence
  a_mlt_not_both: assert property (!(o_tx_mlt.pos && o_tx_mlt.neg))
    else $error("both line outputs high");
  a_mlt_no_pn: assert property ($past(o_tx_mlt.pos) |-> !o_tx_mlt.neg)
    else $error("line jumped from plus to minus");
  a_mlt_no_np: assert property ($past(o_tx_mlt.neg) |-> !o_tx_mlt.pos)
    else $error("line jumped from minus to plus");
  a_plus_alternates: assert property ($rose(o_tx_mlt.pos) |-> !plus_last_reg)
    else $error("two plus excursions without a minus between");
  a_minus_alternates: assert property ($rose(o_tx_mlt.neg) |-> plus_last_reg)
    else $error("two minus excursions without a plus between");
  a_take_pulse: assert property (o_tx_take |=> !o_tx_take)
    else $error("load strobe longer than one cycle");
  a_take_spacing: assert property (s_take |-> gap_reg == 16'(5 * BIT_DIV - 1))
    else $error("group loads not five bit times apart");
  a_dv_pulse: assert property (o_rx.dv |=> !o_rx.dv)
    else $error("nibble strobe longer than one cycle");
  a_er_with_dv: assert property (o_rx.er |-> o_rx.dv)
    else $error("error flag without nibble strobe");
  a_dv_needs_lock: assert property (o_rx.dv |-> o_rx_lock)
    else $error("nibble delivered while unlocked");
  a_sig_loss: assert property (s_sig_gone |=> !o_rx_lock)
    else $error("lock kept after signal loss");
endmodule : fep_coding_props

bind fep_coding fep_coding_props #(.BIT_DIV(BIT_DIV), .LOCK_BITS(LOCK_BITS)) u_props (
  .i_clk_sys, .i_sys_rst, .i_bypass, .i_tx, .o_tx_take, .o_tx_mlt,
  .i_sig_det, .i_rx_mlt, .o_rx, .o_rx_lock
);

// File: verif/fep_mac_model.sv
// Nibble-side partner: presents queued transmit units, collects nibbles.
// Assumes the load strobe of the datapath paces every new unit.
`timescale 1ns/1ps
module fep_mac_model (
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_tx_take,
  input  wire fep_pkg::fep_rx_out_type i_rx,
  output fep_pkg::fep_tx_in_type       o_tx
);
  import fep_pkg::*;
  localparam fep_tx_in_type IDLE_UNIT = '{1'b0, 4'h0, FEP_CG_IDLE};
  fep_tx_in_type txq[$];
  logic [4:0]    rxq[$];
  fep_tx_in_type tx_unit = IDLE_UNIT;
  assign o_tx = tx_unit;
  task automatic put(input fep_tx_in_type item);
    txq.push_back(item);
  endtask : put
  // Next unit goes out just after a load, well before the following one
  always @(negedge i_clk_sys) begin
    if (i_tx_take === 1'b1) begin
      if (txq.size() != 0) begin
        tx_unit <= txq.pop_front();
      end else begin
        tx_unit <= IDLE_UNIT;
      end
    end
  end
  // Nibble strobe is taken mid cycle, where it stands settled
  always @(negedge i_clk_sys) begin
    if (i_rx.dv === 1'b1) begin
      rxq.push_back({i_rx.er, i_rx.nib});
    end
  end
endmodule : fep_mac_model

// File: verif/testbench.sv
// Loopback bench: line outputs feed line inputs; frames go round trip.
// Assumes the partner model drives the nibble side.
`timescale 1ns/1ps
module testbench;
  import fep_pkg::*;
  localparam int BD  = 4;
  localparam int GRP = 5 * BD;
  logic           i_clk_sys;
  logic           i_sys_rst;
  logic           i_bypass;
  logic           i_sig_det;
  logic           o_tx_take;
  logic           o_rx_lock;
  fep_tx_in_type  i_tx;
  fep_mlt_type    o_tx_mlt;
  fep_rx_out_type o_rx;
  int             mismatches;
  int             checks_done;
  // Data code group of each nibble value
  logic [4:0] code_tab [16] = '{5'h1e, 5'h09, 5'h14, 5'h15, 5'h0a, 5'h0b, 5'h0e, 5'h0f,
                                5'h12, 5'h13, 5'h16, 5'h17, 5'h1a, 5'h1b, 5'h1c, 5'h1d};
  fep_coding #(.BIT_DIV(BD), .LOCK_BITS(12)) fep_coding_i (
    .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_bypass(i_bypass), .i_tx(i_tx),
    .o_tx_take(o_tx_take), .o_tx_mlt(o_tx_mlt), .i_sig_det(i_sig_det),
    .i_rx_mlt(o_tx_mlt), .o_rx(o_rx), .o_rx_lock(o_rx_lock)
  );
  fep_mac_model fep_mac_model_i (
    .i_clk_sys(i_clk_sys), .i_tx_take(o_tx_take), .i_rx(o_rx), .o_tx(i_tx)
  );
  initial begin
    i_clk_sys = 1'b0;
    forever #12.5 i_clk_sys = ~i_clk_sys;
  end
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [4:0] got, input logic [4:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Waits for the frame's nibbles, lets trailing groups pass, compares
  task automatic run_frame(input logic [4:0] exp[$], input logic [4:0] msk);
    int n;
    n = 0;
    while (fep_mac_model_i.rxq.size() < exp.size() && n < 200 * GRP) begin
      @(posedge i_clk_sys);
      n++;
    end
    repeat (3 * GRP) @(posedge i_clk_sys);
    chk(5'(fep_mac_model_i.rxq.size()), 5'(exp.size()));
    foreach (exp[k]) begin
      if (k < fep_mac_model_i.rxq.size()) chk(fep_mac_model_i.rxq[k] & msk, exp[k]);
    end
    fep_mac_model_i.rxq.delete();
  endtask : run_frame
  initial begin
    #(20000 * 25);
    mismatches++;
    end_of_test();
  end
  initial begin
    logic [4:0] exp[$];
    int         n;
    i_sys_rst = 1'b1;
    i_bypass  = 1'b0;
    i_sig_det = 1'b1;
    repeat (2) @(negedge i_clk_sys);
    chk({o_tx_take, o_rx_lock, o_rx.dv, o_tx_mlt}, 5'h00);
    @(negedge i_clk_sys);
    i_sys_rst = 1'b0;
    n = 0;
    while (o_rx_lock !== 1'b1 && n < 3000) begin
      @(negedge i_clk_sys);
      n++;
    end
    chk({4'h0, o_rx_lock}, 5'h01);
    fep_mac_model_i.rxq.delete();
    // ---------------------------------------------------------------
    // Coded frame: both lead nibble values are ignored, data 0..F
    // ---------------------------------------------------------------
    fep_mac_model_i.put('{1'b1, 4'h5, 5'h00});
    fep_mac_model_i.put('{1'b1, 4'ha, 5'h00});
    exp = {5'h05, 5'h05};
    for (int v = 0; v < 16; v++) begin
      fep_mac_model_i.put('{1'b1, 4'(v), 5'h00});
      exp.push_back(5'(v));
    end
    fep_mac_model_i.put('{1'b0, 4'h0, 5'h00});
    run_frame(exp, 5'h1f);
    // ---------------------------------------------------------------
    // Raw symbols: the same frame built from the table rows
    // ---------------------------------------------------------------
    @(negedge i_clk_sys);
    i_bypass = 1'b1;
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_J});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_K});
    for (int v = 0; v < 16; v++) fep_mac_model_i.put('{1'b0, 4'h0, code_tab[v]});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_T});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_R});
    run_frame(exp, 5'h1f);
    // Invalid group late in a frame raises the error flag only there
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_J});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_K});
    fep_mac_model_i.put('{1'b0, 4'h0, code_tab[3]});
    fep_mac_model_i.put('{1'b0, 4'h0, 5'h00});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_T});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_R});
    run_frame({5'h00, 5'h00, 5'h00, 5'h10}, 5'h10);
    // Two idles close a frame that has no T/R; idle groups give no nibbles
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_J});
    fep_mac_model_i.put('{1'b0, 4'h0, FEP_CG_K});
    fep_mac_model_i.put('{1'b0, 4'h0, code_tab[9]});
    run_frame({5'h05, 5'h05, 5'h09}, 5'h1f);
    @(negedge i_clk_sys);
    i_bypass  = 1'b0;
    i_sig_det = 1'b0;
    repeat (6) @(negedge i_clk_sys);
    chk({4'h0, o_rx_lock}, 5'h00);
    end_of_test();
  end
endmodule : testbench
